//--- rtl/gate_veto_pkg.sv
package gate_veto_pkg;

    // Channel and pin counts.
    localparam int NUM_CHAN   = 16;
    localparam int NUM_PAIR   = 4;
    localparam int NUM_FDI    = 6;
    localparam int NUM_TEST   = 6;
    localparam int SYNC_WIDTH = 28;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_CHAN_SENSE  = 8'h00;
    localparam logic [7:0] OFF_MOD_CTRL    = 8'h04;
    localparam logic [7:0] OFF_PAIR_DIR    = 8'h08;
    localparam logic [7:0] OFF_PAIR_OUT    = 8'h0C;
    localparam logic [7:0] OFF_TEST_SEL    = 8'h10;
    localparam logic [7:0] OFF_GATE_STATUS = 8'h14;
    localparam logic [7:0] OFF_ACCEPT_CNT  = 8'h18;
    localparam logic [7:0] OFF_DISCARD_CNT = 8'h1C;

    // Values after reset: every gate in veto sense, every pair an input.
    localparam logic [15:0] RST_CHAN_SENSE = 16'h0000;
    localparam logic        RST_MOD_SENSE  = 1'b0;
    localparam logic [3:0]  RST_PAIR_DIR   = 4'h0;
    localparam logic [3:0]  RST_PAIR_OUT   = 4'h0;
    localparam logic [1:0]  RST_TEST_SEL   = 2'h0;
    localparam logic [15:0] RST_COUNT      = 16'h0000;

    // Field positions in the module control register.
    localparam int MOD_SENSE_BIT = 0;

    // Field positions in the gate status register.
    localparam int STAT_CHAN_LSB  = 0;
    localparam int STAT_MOD_BIT   = 16;
    localparam int STAT_SPARE_BIT = 17;
    localparam int STAT_FDI_LSB   = 18;
    localparam int STAT_PAIR_LSB  = 24;

    // Test output views.
    localparam logic [1:0] TSEL_GATES  = 2'h0;
    localparam logic [1:0] TSEL_DECIDE = 2'h1;
    localparam logic [1:0] TSEL_INPUTS = 2'h2;
    localparam logic [1:0] TSEL_PAIRS  = 2'h3;

    // Synchronised front-panel levels; the packing matches the status
    // register layout from bit 0 upward.
    typedef struct packed {
        logic [NUM_PAIR-1:0] pair;
        logic [NUM_FDI-1:0]  fdi;
        logic                spare;
        logic                module_gate;
        logic [NUM_CHAN-1:0] chan;
    } gate_levels_type;

endpackage

//--- rtl/level_sync.sv
`timescale 1ns/1ps

module level_sync
    import gate_veto_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    // A rising level counts only once the second and third stages agree, but
    // the level falls as soon as they disagree, so only a single-cycle high
    // glitch that slips through the first stage is ignored.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = din;
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        st_nxt.level = (st_r.s2 & st_r.s3)
                     | (st_r.level & ~(st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.level;

endmodule

//--- rtl/trigger_gate_veto_logic.sv
// What this block does
// - Sixteen channel gates each decide the fate of their own channel only.
// - A channel gate is a level that counts when high and is idle when low.
// - In veto sense a channel trigger that meets a high channel gate is lost.
// - Software can turn each channel gate from veto into validation sense.
// - In validation sense a channel trigger is kept only with its gate high.
// - One module gate acts on the acceptance of all sixteen channels.
// - The module gate is a level that counts when high and is idle when low.
// - In veto sense a high module gate drops the trigger of every channel.
// - In validation sense a trigger is kept only while the module gate is up.
// - The four differential pairs each have a software-set direction.
// - Six test outputs show internal state chosen by software.
// - The six digital inputs are handed on for firmware-defined use.
// - The spare gate is synchronised and reported but has no effect.
`timescale 1ns/1ps

module trigger_gate_veto_logic
    import gate_veto_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    input  wire logic [NUM_CHAN-1:0] fast_trig,
    input  wire logic [NUM_CHAN-1:0] channel_gate_in,
    input  wire logic                module_gate_in,
    input  wire logic                spare_gate_in,
    input  wire logic [NUM_FDI-1:0]  front_digital_in,
    input  wire logic [NUM_PAIR-1:0] diff_pair_in,
    output logic      [NUM_PAIR-1:0] diff_pair_out,
    output logic      [NUM_PAIR-1:0] diff_pair_oe_n,
    output logic      [NUM_CHAN-1:0] trig_accept,
    output logic      [NUM_CHAN-1:0] trig_discard,
    output logic      [NUM_TEST-1:0] front_test_out,
    output gate_levels_type          gate_levels
);

    typedef struct packed {
        logic [NUM_CHAN-1:0] chan_sense;
        logic                mod_sense;
        logic [NUM_PAIR-1:0] pair_dir;
        logic [NUM_PAIR-1:0] pair_out;
        logic [1:0]          test_sel;
        logic [31:0]         rdata;
        logic                slverr;
        logic [NUM_CHAN-1:0] accept;
        logic [NUM_CHAN-1:0] discard;
        logic [NUM_TEST-1:0] test_out;
        logic [15:0]         accept_cnt;
        logic [15:0]         discard_cnt;
    } gate_state_type;

    gate_state_type      st_r;
    gate_state_type      st_nxt;
    gate_levels_type     lv;
    logic [NUM_CHAN-1:0] chan_ok;
    logic                mod_ok;
    logic [NUM_CHAN-1:0] acc_now;
    logic [NUM_CHAN-1:0] dis_now;
    logic [4:0]          n_acc;
    logic [4:0]          n_dis;
    logic                setup_ph;
    logic                wr_ph;

    // Every pin level crosses through one synchroniser bank.
    level_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({diff_pair_in, front_digital_in, spare_gate_in,
                   module_gate_in, channel_gate_in}),
        .dout    (lv)
    );

    // A gate counts as effective only while high, and the sense bit decides
    // whether effective means drop or keep.
    assign chan_ok = ~(lv.chan ^ st_r.chan_sense);
    assign mod_ok  = ~(lv.module_gate ^ st_r.mod_sense);
    assign acc_now = fast_trig & chan_ok & {NUM_CHAN{mod_ok}};
    assign dis_now = fast_trig & ~(chan_ok & {NUM_CHAN{mod_ok}});

    always_comb begin
        n_acc = 5'h00;
        n_dis = 5'h00;
        for (int i = 0; i < NUM_CHAN; i++) begin
            n_acc = n_acc + {4'h0, st_r.accept[i]};
            n_dis = n_dis + {4'h0, st_r.discard[i]};
        end
    end

    assign setup_ph = psel && !penable;
    assign wr_ph    = psel && penable && pwrite;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.accept  = acc_now;
        st_nxt.discard = dis_now;

        // The spare gate is only reported; custom logic may use it later.
        case (st_r.test_sel)
            TSEL_GATES: begin
                st_nxt.test_out = {lv.spare, lv.module_gate,
                                   lv.chan[3:0]};
            end
            TSEL_DECIDE: begin
                st_nxt.test_out = {|st_r.accept, |st_r.discard, mod_ok,
                                   lv.module_gate, lv.spare, |fast_trig};
            end
            TSEL_INPUTS: begin
                st_nxt.test_out = lv.fdi;
            end
            TSEL_PAIRS: begin
                st_nxt.test_out = {2'h0, lv.pair};
            end
            default: begin
                st_nxt.test_out = '0;
            end
        endcase

        // Counters clear on write; a count arriving in the same cycle is
        // added on top so that no trigger goes uncounted.
        st_nxt.accept_cnt  = st_r.accept_cnt + {11'h000, n_acc};
        st_nxt.discard_cnt = st_r.discard_cnt + {11'h000, n_dis};

        // Read data and error are fixed in the setup cycle so that both
        // come from flip-flops during the access cycle.
        if (setup_ph) begin
            st_nxt.rdata  = 32'h0000_0000;
            st_nxt.slverr = 1'b0;
            case (paddr)
                OFF_CHAN_SENSE: begin
                    st_nxt.rdata[NUM_CHAN-1:0] = st_r.chan_sense;
                end
                OFF_MOD_CTRL: begin
                    st_nxt.rdata[MOD_SENSE_BIT] = st_r.mod_sense;
                end
                OFF_PAIR_DIR: begin
                    st_nxt.rdata[NUM_PAIR-1:0] = st_r.pair_dir;
                end
                OFF_PAIR_OUT: begin
                    st_nxt.rdata[NUM_PAIR-1:0] = st_r.pair_out;
                end
                OFF_TEST_SEL: begin
                    st_nxt.rdata[1:0] = st_r.test_sel;
                end
                OFF_GATE_STATUS: begin
                    st_nxt.rdata[SYNC_WIDTH-1:0] = lv;
                end
                OFF_ACCEPT_CNT: begin
                    st_nxt.rdata[15:0] = st_r.accept_cnt;
                end
                OFF_DISCARD_CNT: begin
                    st_nxt.rdata[15:0] = st_r.discard_cnt;
                end
                default: begin
                    st_nxt.slverr = 1'b1;
                end
            endcase
        end

        if (wr_ph) begin
            case (paddr)
                OFF_CHAN_SENSE: begin
                    st_nxt.chan_sense = pwdata[NUM_CHAN-1:0];
                end
                OFF_MOD_CTRL: begin
                    st_nxt.mod_sense = pwdata[MOD_SENSE_BIT];
                end
                OFF_PAIR_DIR: begin
                    st_nxt.pair_dir = pwdata[NUM_PAIR-1:0];
                end
                OFF_PAIR_OUT: begin
                    st_nxt.pair_out = pwdata[NUM_PAIR-1:0];
                end
                OFF_TEST_SEL: begin
                    st_nxt.test_sel = pwdata[1:0];
                end
                OFF_ACCEPT_CNT: begin
                    st_nxt.accept_cnt = {11'h000, n_acc};
                end
                OFF_DISCARD_CNT: begin
                    st_nxt.discard_cnt = {11'h000, n_dis};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.chan_sense  <= RST_CHAN_SENSE;
            st_r.mod_sense   <= RST_MOD_SENSE;
            st_r.pair_dir    <= RST_PAIR_DIR;
            st_r.pair_out    <= RST_PAIR_OUT;
            st_r.test_sel    <= RST_TEST_SEL;
            st_r.rdata       <= 32'h0000_0000;
            st_r.slverr      <= 1'b0;
            st_r.accept      <= '0;
            st_r.discard     <= '0;
            st_r.test_out    <= '0;
            st_r.accept_cnt  <= RST_COUNT;
            st_r.discard_cnt <= RST_COUNT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero wait states: the slave answers in the first access cycle.
    assign pready         = psel && penable;
    assign prdata         = st_r.rdata;
    assign pslverr        = st_r.slverr;
    // A pair set as output is driven from its register; oe_n low drives.
    assign diff_pair_out  = st_r.pair_out;
    assign diff_pair_oe_n = ~st_r.pair_dir;
    assign trig_accept    = st_r.accept;
    assign trig_discard   = st_r.discard;
    assign front_test_out = st_r.test_out;
    assign gate_levels    = lv;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_gate0_high_held;
        channel_gate_in[0] [*4];
    endsequence

    sequence s_fdi0_high_held;
        front_digital_in[0] [*4];
    endsequence

    property p_chan_only_own;
        1 |=> ((trig_accept | trig_discard) == $past(fast_trig))
              && ((trig_accept & trig_discard) == '0);
    endproperty
    a_chan_only_own: assert property (p_chan_only_own)
        else $error("decision not tied to its own channel trigger");

    property p_chan_veto;
        1 |=> (trig_accept & $past(~st_r.chan_sense & lv.chan)) == '0;
    endproperty
    a_chan_veto: assert property (p_chan_veto)
        else $error("trigger kept although channel gate vetoed it");

    property p_sense_write;
        (wr_ph && paddr == OFF_CHAN_SENSE)
            |=> st_r.chan_sense == $past(pwdata[NUM_CHAN-1:0]);
    endproperty
    a_sense_write: assert property (p_sense_write)
        else $error("channel gate sense not taken from write");

    property p_chan_valid;
        1 |=> (trig_accept & $past(st_r.chan_sense & ~lv.chan)) == '0;
    endproperty
    a_chan_valid: assert property (p_chan_valid)
        else $error("trigger kept without channel validation");

    property p_module_all;
        (mod_ok && chan_ok == 16'hFFFF) |=> trig_accept == $past(fast_trig);
    endproperty
    a_module_all: assert property (p_module_all)
        else $error("open gates did not pass every channel trigger");

    property p_mod_veto;
        (lv.module_gate && !st_r.mod_sense) |=> trig_accept == '0;
    endproperty
    a_mod_veto: assert property (p_mod_veto)
        else $error("trigger kept although module gate vetoed it");

    property p_mod_valid;
        (!lv.module_gate && st_r.mod_sense) |=> trig_accept == '0;
    endproperty
    a_mod_valid: assert property (p_mod_valid)
        else $error("trigger kept without module validation");

    property p_pair_dir;
        (wr_ph && paddr == OFF_PAIR_DIR)
            |=> diff_pair_oe_n == ~$past(pwdata[NUM_PAIR-1:0]);
    endproperty
    a_pair_dir: assert property (p_pair_dir)
        else $error("pair direction did not follow the write");

    property p_test_gates;
        (st_r.test_sel == TSEL_GATES)
            |=> front_test_out == $past({lv.spare, lv.module_gate,
                                         lv.chan[3:0]});
    endproperty
    a_test_gates: assert property (p_test_gates)
        else $error("test outputs do not show the gate levels");

    property p_fdi_pass;
        s_fdi0_high_held |=> gate_levels.fdi[0];
    endproperty
    a_fdi_pass: assert property (p_fdi_pass)
        else $error("digital input level not handed on");

    property p_both_gates;
        1 |=> trig_accept == $past(fast_trig & chan_ok
                                   & {NUM_CHAN{mod_ok}});
    endproperty
    a_both_gates: assert property (p_both_gates)
        else $error("accept differs from combined gate decision");

    property p_gate_sync;
        s_gate0_high_held |=> lv.chan[0] ##1 lv.chan[0] || !channel_gate_in[0];
    endproperty
    a_gate_sync: assert property (p_gate_sync)
        else $error("held channel gate level not synchronised");

    property p_chan_idle;
        1 |=> (trig_discard & $past(fast_trig & ~lv.chan & ~st_r.chan_sense
                                    & {NUM_CHAN{mod_ok}})) == '0;
    endproperty
    a_chan_idle: assert property (p_chan_idle)
        else $error("idle channel gate dropped a trigger");

    property p_mod_idle;
        (!lv.module_gate && !st_r.mod_sense)
            |=> trig_discard == $past(fast_trig & ~chan_ok);
    endproperty
    a_mod_idle: assert property (p_mod_idle)
        else $error("idle module gate dropped a trigger");

    property p_pair_out;
        (wr_ph && paddr == OFF_PAIR_OUT)
            |=> diff_pair_out == $past(pwdata[NUM_PAIR-1:0]);
    endproperty
    a_pair_out: assert property (p_pair_out)
        else $error("pair drive value did not follow the write");

endmodule

//--- verification/gate_source.sv
`timescale 1ns/1ps

// Model of the external veto and validation electronics. The pins change
// just after the rising clock edge, like every other driven input, and
// the design still treats them as unrelated to its clock. In slow mode
// each change reaches the pins one cycle late.
module gate_source
    import gate_veto_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      slow,
    input  gate_levels_type want,
    output gate_levels_type pins = '0
);
    gate_levels_type stage = '0;

    always @(posedge pclk) begin
        stage <= want;
    end

    // Gate levels are held as plain levels; a high level is an active gate.
    always @(posedge pclk) begin
        pins <= slow ? stage : want;
    end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps

module testbench
    import gate_veto_pkg::*;
;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [31:0]         pwdata = 32'h0;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic [NUM_CHAN-1:0] fast_trig = '0;
    logic [NUM_PAIR-1:0] diff_pair_out;
    logic [NUM_PAIR-1:0] diff_pair_oe_n;
    logic [NUM_CHAN-1:0] trig_accept;
    logic [NUM_CHAN-1:0] trig_discard;
    logic [NUM_TEST-1:0] front_test_out;
    gate_levels_type     gate_levels;
    gate_levels_type     want = '0;
    gate_levels_type     pins;
    gate_levels_type     gl;
    logic                slow = 1'b0;
    int                  bad_count = 0;
    int                  num_checks = 0;
    int                  cycles = 0;
    integer              seed = 32'h64eb9a83;

    trigger_gate_veto_logic trigger_gate_veto_logic_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fast_trig(fast_trig), .channel_gate_in(pins.chan),
        .module_gate_in(pins.module_gate), .spare_gate_in(pins.spare),
        .front_digital_in(pins.fdi), .diff_pair_in(pins.pair),
        .diff_pair_out(diff_pair_out), .diff_pair_oe_n(diff_pair_oe_n),
        .trig_accept(trig_accept), .trig_discard(trig_discard),
        .front_test_out(front_test_out), .gate_levels(gate_levels)
    );

    gate_source gate_source_i (
        .pclk(pclk), .slow(slow), .want(want), .pins(pins)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    task report_and_stop;
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hang in a bus wait would otherwise stall the run for ever.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Kept triggers: the gate must equal its sense bit, for both gates.
    function automatic logic [15:0] keep(logic [15:0] t, logic [15:0] cs,
                                         logic ms, gate_levels_type l);
        return t & ~(l.chan ^ cs) & {16{l.module_gate == ms}};
    endfunction

    function automatic logic [5:0] tview(logic [1:0] s, gate_levels_type l,
                                         logic ms);
        case (s)
            TSEL_GATES:  return {l.spare, l.module_gate, l.chan[3:0]};
            TSEL_DECIDE: return {2'b00, l.module_gate == ms, l.module_gate,
                                 l.spare, 1'b0};
            TSEL_INPUTS: return l.fdi;
            default:     return {2'b00, l.pair};
        endcase
    endfunction

    logic [31:0] q;
    logic [31:0] r;
    logic        e;
    logic [15:0] cs;
    logic [15:0] trg;
    logic [15:0] kept;
    logic        ms;
    logic [3:0]  dir;
    logic [3:0]  pout;

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q, e);
            check(q, 32'h0);
        end
        check(diff_pair_oe_n, 4'hF);
        apb(1'b0, 8'h20, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        apb(1'b1, 8'h02, 32'hFFFF, q, e);
        check({31'h0, e}, 32'h1);
        apb(1'b0, OFF_CHAN_SENSE, 32'h0, q, e);
        check(q, 32'h0);
        for (int n = 0; n < 16; n++) begin
            r = $random(seed);
            gl = r[27:0];
            cs = 16'($random(seed));
            r = $random(seed);
            ms = r[0];
            slow <= r[1];
            dir = r[7:4];
            pout = r[11:8];
            trg = r[31:16];
            if (n == 0) begin
                gl.chan = '0;
                gl.module_gate = 1'b0;
                cs = '0;
                ms = 1'b0;
                trg = '1;
            end
            if (n == 1) begin
                gl.chan = '1;
                gl.module_gate = 1'b1;
                cs = '1;
                ms = 1'b1;
                trg = '1;
            end
            want <= gl;
            apb(1'b1, OFF_CHAN_SENSE, {16'h0, cs}, q, e);
            apb(1'b1, OFF_MOD_CTRL, {31'h0, ms}, q, e);
            apb(1'b1, OFF_PAIR_DIR, {28'h0, dir}, q, e);
            apb(1'b1, OFF_PAIR_OUT, {28'h0, pout}, q, e);
            apb(1'b1, OFF_TEST_SEL, 32'(n % 4), q, e);
            apb(1'b1, OFF_ACCEPT_CNT, 32'h0, q, e);
            apb(1'b1, OFF_DISCARD_CNT, 32'h0, q, e);
            check({diff_pair_oe_n, diff_pair_out}, {~dir, pout});
            repeat (8) @(posedge pclk);
            check(gate_levels, want);
            apb(1'b1, OFF_GATE_STATUS, 32'h0, q, e);
            apb(1'b0, OFF_GATE_STATUS, 32'h0, q, e);
            check(q, {4'h0, want});
            check(front_test_out, tview(2'(n % 4), want, ms));
            @(posedge pclk);
            fast_trig <= trg;
            @(posedge pclk);
            fast_trig <= '0;
            #1;
            kept = keep(trg, cs, ms, want);
            check(trig_accept, kept);
            check(trig_discard, trg & ~kept);
            apb(1'b0, OFF_ACCEPT_CNT, 32'h0, q, e);
            check(q, 32'($countones(kept)));
            apb(1'b0, OFF_DISCARD_CNT, 32'h0, q, e);
            check(q, 32'($countones(trg & ~kept)));
        end
        report_and_stop();
    end
endmodule
